// ===== common/acc_pkg.sv
// converter control constants: register map, fields, resets, timing
// assumes a 32-bit axi4-lite slave with one register per aligned word
`default_nettype none
package acc_pkg;
    // register indices, byte address = 4 * index
    localparam logic [15:0] IDX_CTRL_FIRST  = 16'h000e; // converter_control_first
    localparam logic [15:0] IDX_CTRL_SECOND = 16'h000f; // converter_control_second
    localparam logic [15:0] IDX_RESULT      = 16'h0020; // conversion_result
    localparam logic [15:0] IDX_STATUS      = 16'h0021; // conversion_status
    localparam int          ADDR_W          = 8;        // byte address width
    localparam logic [7:0]  ADDR_CTRL_FIRST  = 8'h38;
    localparam logic [7:0]  ADDR_CTRL_SECOND = 8'h3c;
    localparam logic [7:0]  ADDR_RESULT      = 8'h80;
    localparam logic [7:0]  ADDR_STATUS      = 8'h84;
    // first control register fields
    localparam int          F1_START     = 7; // conversion_start_bit
    localparam int          F1_AIN_DIS   = 4; // analog_input_disable
    localparam logic [7:0]  F1_RESET     = 8'h10; // reset value
    localparam logic [7:0]  F1_FIXED     = 8'h20; // bit 5 reads one, bit 6 zero
    // second control register fields
    localparam int          F2_LADDER    = 5; // ladder_connection_control
    localparam logic [7:0]  F2_FIXED     = 8'h10; // bit 4 reads one
    localparam logic [7:0]  F2_RESET     = 8'h10;
    // status fields
    localparam int          ST_DONE      = 5;
    localparam int          ST_BUSY      = 4;
    // conversion times in block clock cycles
    localparam logic [10:0] T_CONV_000   = 11'd39;
    localparam logic [10:0] T_CONV_010   = 11'd78;
    localparam logic [10:0] T_CONV_011   = 11'd156;
    localparam logic [10:0] T_CONV_100   = 11'd312;
    localparam logic [10:0] T_CONV_101   = 11'd624;
    localparam logic [10:0] T_CONV_110   = 11'd1248;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    // converter state
    typedef enum logic [0:0] {
        ACC_IDLE = 1'b0,
        ACC_CONV = 1'b1
    } acc_state_t;
endpackage : acc_pkg
`default_nettype wire

// ===== rtl/acc_timer.sv
// conversion-time countdown, pulses when the time is up
// assumes load and abort share its clock
`default_nettype none
module acc_timer (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // control
    input  wire logic       load_i,   // start a countdown
    input  wire logic       abort_i,  // cancel a running countdown
    input  wire logic [2:0] code_i,   // conversion time select
    // status
    output logic            done_o    // pulse when time is up
);
    import acc_pkg::*;

    logic [10:0] cnt_r;      // remaining cycles
    logic        run_r;      // countdown active
    logic [10:0] len;        // decoded length

    // decode time code, reserved codes give the shortest
    always_comb begin
        case (code_i)
            3'b010:  len = T_CONV_010;
            3'b011:  len = T_CONV_011;
            3'b100:  len = T_CONV_100;
            3'b101:  len = T_CONV_101;
            3'b110:  len = T_CONV_110;
            default: len = T_CONV_000;
        endcase
    end

    // count down the full time
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || abort_i) begin
            run_r <= 1'b0;
            cnt_r <= 11'h000;
        end else if (load_i) begin
            run_r <= 1'b1;
            cnt_r <= len - 11'd1;
        end else if (run_r) begin
            if (cnt_r == 11'h000) begin
                run_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 11'd1;
            end
        end
    end

    assign done_o = run_r && (cnt_r == 11'h000) && !abort_i;
endmodule : acc_timer
`default_nettype wire

// ===== rtl/acc_top.sv
// converter control top: registers, conversion flow, low-power abort
// assumes the front end holds its 8-bit code on ADC_CODE_I
//
// Functional notes
// - start bit write begins selected channel conversion
// - start bit clears itself after conversion begins
// - busy set on start, cleared on finish/low-power
// - completion loads result, sets done, pulses interrupt
// - result appears only after selected time
// - reading result clears done flag
// - restart clears done, old result kept
// - status read-only, done bit5, busy bit4
// - status bits 7,6,3..0 undefined
// - second control bits 7,6 undefined
// - low-power entry aborts, resets control, result lost
// - after low-power, idle until new start
// - reference disconnected in low-power modes
// - result is unsigned 8-bit code
// - channel codes 0..7 map inputs, others reserved
// - time codes give 39..1248 fc cycles
// - ladder connects during conversion or always
// - control registers held at reset in low-power
//
// Our own choice: register access over AXI4-Lite.
`default_nettype none
module acc_top (
    // clock and reset
    input  wire logic                      CLK_I,
    input  wire logic                      RST_N_I,
    // axi4-lite write address
    input  wire logic [acc_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic                      S_AXI_AWVALID_I,
    output logic                           S_AXI_AWREADY_O,
    // axi4-lite write data
    input  wire logic [31:0]               S_AXI_WDATA_I,
    input  wire logic [3:0]                S_AXI_WSTRB_I,
    input  wire logic                      S_AXI_WVALID_I,
    output logic                           S_AXI_WREADY_O,
    // axi4-lite write response
    output logic [1:0]                     S_AXI_BRESP_O,
    output logic                           S_AXI_BVALID_O,
    input  wire logic                      S_AXI_BREADY_I,
    // axi4-lite read address
    input  wire logic [acc_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic                      S_AXI_ARVALID_I,
    output logic                           S_AXI_ARREADY_O,
    // axi4-lite read data
    output logic [31:0]                    S_AXI_RDATA_O,
    output logic [1:0]                     S_AXI_RRESP_O,
    output logic                           S_AXI_RVALID_O,
    input  wire logic                      S_AXI_RREADY_I,
    // power mode
    input  wire logic                      LOW_POWER_I,  // stop, slow or sleep active
    // analog front end
    input  wire logic [7:0]                ADC_CODE_I,   // comparator result code
    output logic [2:0]                     ADC_CHANNEL_O,  // analog input select
    output logic                           ADC_CHANNEL_VALID_O, // code not reserved
    output logic                           ADC_AIN_DISABLE_O,  // analog inputs disabled
    output logic                           ADC_SAMPLE_O,   // sample-and-hold active
    output logic                           LADDER_CONNECT_O, // ladder connected
    output logic                           VREF_CONNECT_O,   // reference connected
    // events
    output logic                           CONV_DONE_IRQ_O   // conversion_done_interrupt pulse
);
    import acc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] lp_sync_r;     // low-power sync chain
    logic [7:0] code_s1_r;     // code first stage
    logic [7:0] code_s2_r;     // code second stage
    logic       low_power;     // synchronised mode

    // two flops for the mode pin
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            lp_sync_r <= 2'b00;
        end else begin
            lp_sync_r <= {lp_sync_r[0], LOW_POWER_I};
        end
    end
    assign low_power = lp_sync_r[1];

    // two flops for the analog code
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            code_s1_r <= 8'h00;
            code_s2_r <= 8'h00;
        end else begin
            code_s1_r <= ADC_CODE_I;
            code_s2_r <= code_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave handshakes
    logic                aw_held_r;   // write address captured
    logic [ADDR_W-1:0]   aw_addr_r;   // captured write address
    logic                w_held_r;    // write data captured
    logic [31:0]         w_data_r;    // captured data
    logic [3:0]          w_strb_r;    // captured strobes
    logic                bvalid_r;    // write response pending
    logic [1:0]          bresp_r;     // write response code
    logic                rvalid_r;    // read data pending
    logic [31:0]         rdata_r;     // read data
    logic [1:0]          rresp_r;     // read response code
    logic                wr_go;       // write commits
    logic                rd_go;       // read commits
    logic                wr_hit_c1;   // write to first control
    logic                wr_hit_c2;   // write to second control
    logic                wr_map;      // write address mapped
    logic                rd_hit_res;  // read of result

    assign S_AXI_AWREADY_O = !aw_held_r && !bvalid_r;
    assign S_AXI_WREADY_O  = !w_held_r && !bvalid_r;
    assign S_AXI_ARREADY_O = !rvalid_r;
    assign S_AXI_BVALID_O  = bvalid_r;
    assign S_AXI_BRESP_O   = bresp_r;
    assign S_AXI_RVALID_O  = rvalid_r;
    assign S_AXI_RDATA_O   = rdata_r;
    assign S_AXI_RRESP_O   = rresp_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;
    assign rd_go = S_AXI_ARVALID_I && !rvalid_r;

    // capture address and data, any order
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR_I;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held_r <= 1'b1;
                w_data_r <= S_AXI_WDATA_I;
                w_strb_r <= S_AXI_WSTRB_I;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write address decode
    always_comb begin
        wr_hit_c1 = 1'b0;
        wr_hit_c2 = 1'b0;
        wr_map    = 1'b1;
        if (aw_addr_r == ADDR_CTRL_FIRST) begin
            wr_hit_c1 = wr_go && w_strb_r[0];
        end else if (aw_addr_r == ADDR_CTRL_SECOND) begin
            wr_hit_c2 = wr_go && w_strb_r[0];
        end else if (aw_addr_r == ADDR_RESULT || aw_addr_r == ADDR_STATUS) begin
            wr_map = 1'b1; // read-only, write dropped
        end else begin
            wr_map = 1'b0;
        end
    end

    // write response
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers and converter state
    acc_state_t  state_r;      // idle or converting
    logic [3:0]  chan_r;       // channel_select
    logic        ain_dis_r;    // analog_input_disable
    logic [2:0]  time_r;       // conversion time select
    logic        ladder_r;     // ladder_connection_control
    logic [7:0]  result_r;     // conversion_result
    logic        done_r;       // conversion_done_flag
    logic        irq_r;        // interrupt pulse
    logic        start;        // accepted start request
    logic        finish;       // countdown elapsed

    // start only from idle
    assign start = wr_hit_c1 && w_data_r[F1_START] && (state_r == ACC_IDLE) && !low_power;

    // countdown of the selected time
    acc_timer i_acc_timer (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .load_i  (start),
        .abort_i (low_power),
        .code_i  (time_r),
        .done_o  (finish)
    );

    // first control register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || low_power) begin
            chan_r    <= F1_RESET[3:0];
            ain_dis_r <= F1_RESET[F1_AIN_DIS];
        end else if (wr_hit_c1) begin
            chan_r    <= w_data_r[3:0];
            ain_dis_r <= w_data_r[F1_AIN_DIS];
        end
    end

    // second control register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || low_power) begin
            time_r   <= F2_RESET[3:1];
            ladder_r <= F2_RESET[F2_LADDER];
        end else if (wr_hit_c2) begin
            time_r   <= w_data_r[3:1];
            ladder_r <= w_data_r[F2_LADDER];
        end
    end

    // busy state machine
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || low_power) begin
            state_r <= ACC_IDLE;
        end else begin
            case (state_r)
                ACC_IDLE: begin
                    if (start) begin
                        state_r <= ACC_CONV;
                    end
                end
                ACC_CONV: begin
                    if (finish) begin
                        state_r <= ACC_IDLE;
                    end
                end
                default: state_r <= ACC_IDLE;
            endcase
        end
    end

    // result register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || low_power) begin
            result_r <= 8'h00;
        end else if (finish) begin
            result_r <= code_s2_r;
        end
    end

    // done flag: completion wins over a result read
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || low_power) begin
            done_r <= 1'b0;
        end else if (finish) begin
            done_r <= 1'b1;
        end else if (start) begin
            done_r <= 1'b0;
        end else if (rd_go && rd_hit_res) begin
            done_r <= 1'b0;
        end
    end

    // interrupt pulse on completion
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= finish;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path
    logic [31:0] rd_word;      // decoded read value
    logic        rd_map;       // read address mapped

    // read address decode
    always_comb begin
        rd_word    = 32'h0000_0000;
        rd_map     = 1'b1;
        rd_hit_res = 1'b0;
        if (S_AXI_ARADDR_I == ADDR_CTRL_FIRST) begin
            // start bit always reads zero once taken
            rd_word[7:0] = F1_FIXED | {3'b000, ain_dis_r, chan_r};
        end else if (S_AXI_ARADDR_I == ADDR_CTRL_SECOND) begin
            // bits 7,6 undefined, driven zero
            rd_word[7:0] = F2_FIXED | {2'b00, ladder_r, 1'b0, time_r, 1'b0};
        end else if (S_AXI_ARADDR_I == ADDR_RESULT) begin
            rd_word[7:0] = result_r;
            rd_hit_res   = 1'b1;
        end else if (S_AXI_ARADDR_I == ADDR_STATUS) begin
            // undefined bits driven zero
            rd_word[ST_DONE] = done_r;
            rd_word[ST_BUSY] = (state_r == ACC_CONV);
        end else begin
            rd_map = 1'b0;
        end
    end

    // read data register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY_I) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog front-end controls
    logic [2:0] chan_out_r;    // registered channel select
    logic       chan_ok_r;     // registered channel valid
    logic       ladder_out_r;  // registered ladder connect
    logic       vref_out_r;    // registered reference connect
    logic       sample_r;      // registered sample enable
    logic       ain_out_r;     // registered input disable

    // analog controls from flops
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            chan_out_r   <= 3'b000;
            chan_ok_r    <= 1'b0;
            ladder_out_r <= 1'b0;
            vref_out_r   <= 1'b0;
            sample_r     <= 1'b0;
            ain_out_r    <= 1'b1;
        end else begin
            chan_out_r   <= chan_r[2:0];
            chan_ok_r    <= !chan_r[3];
            ladder_out_r <= !low_power && (ladder_r || state_r == ACC_CONV);
            vref_out_r   <= !low_power && (ladder_r || state_r == ACC_CONV);
            sample_r     <= (state_r == ACC_CONV) && !low_power;
            ain_out_r    <= ain_dis_r;
        end
    end

    assign ADC_CHANNEL_O       = chan_out_r;
    assign ADC_CHANNEL_VALID_O = chan_ok_r;
    assign ADC_AIN_DISABLE_O   = ain_out_r;
    assign ADC_SAMPLE_O        = sample_r;
    assign LADDER_CONNECT_O    = ladder_out_r;
    assign VREF_CONNECT_O      = vref_out_r;
    assign CONV_DONE_IRQ_O     = irq_r;
endmodule : acc_top
`default_nettype wire

// ===== testbench/acc_top_assertions.sv
// checker for acc_top: bus, status, conversion, low power
// assumes binding into acc_top, ports by name
`default_nettype none
module acc_top_assertions
    import acc_pkg::*;
(
    // clock, reset, power mode
    input wire logic              CLK_I,
    input wire logic              RST_N_I,
    input wire logic              LOW_POWER_I,
    // read channels
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic              S_AXI_ARVALID_I,
    input wire logic              S_AXI_ARREADY_O,
    input wire logic [31:0]       S_AXI_RDATA_O,
    input wire logic              S_AXI_RVALID_O,
    // write response
    input wire logic              S_AXI_BVALID_O,
    input wire logic              S_AXI_BREADY_I,
    // front end and event
    input wire logic              ADC_SAMPLE_O,
    input wire logic              LADDER_CONNECT_O,
    input wire logic              VREF_CONNECT_O,
    input wire logic              CONV_DONE_IRQ_O
);
    logic [10:0] len_r;  // cycles the sample output has been high
    logic [1:0]  rsel_r; // open read: bit1 first control, bit0 status
    ////////////////////////////////////////////////////////////////
    // length of the sampling period
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) len_r <= '0;
        else if (ADC_SAMPLE_O) len_r <= len_r + 11'd1;
        else len_r <= '0;
    end
    // which register the open read targets
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) rsel_r <= '0;
        else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
            rsel_r <= {S_AXI_ARADDR_I == ADDR_CTRL_FIRST, S_AXI_ARADDR_I == ADDR_STATUS};
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_conv_min_time: assert property ($fell(ADC_SAMPLE_O) && !LOW_POWER_I |-> len_r >= 11'd37)
        else $error("conversion too short");
    a_irq_one_pulse: assert property (CONV_DONE_IRQ_O |=> !CONV_DONE_IRQ_O)
        else $error("done event too long");
    a_irq_after_end: assert property (CONV_DONE_IRQ_O |=> !ADC_SAMPLE_O)
        else $error("sampling after done");
    a_lp_disconnect: assert property (LOW_POWER_I [*4] |-> !VREF_CONNECT_O && !ADC_SAMPLE_O)
        else $error("active in low power");
    a_vref_ladder: assert property (ADC_SAMPLE_O |-> LADDER_CONNECT_O && VREF_CONNECT_O)
        else $error("ladder off while sampling");
    a_b_release: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
        else $error("write response stuck");
    a_r_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read answer late");
    a_upper_zero: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0)
        else $error("upper read bits set");
    a_status_layout: assert property (S_AXI_RVALID_O && rsel_r[0] |->
        S_AXI_RDATA_O[7:6] == 2'b00 && S_AXI_RDATA_O[3:0] == 4'h0 && !(S_AXI_RDATA_O[5] && S_AXI_RDATA_O[4]))
        else $error("bad status layout");
    a_start_clear: assert property (S_AXI_RVALID_O && rsel_r[1] |-> !S_AXI_RDATA_O[F1_START])
        else $error("start bit reads set");
    c_done_event: cover property (CONV_DONE_IRQ_O);
    c_lp_abort: cover property (LOW_POWER_I && ADC_SAMPLE_O);
    c_done_read: cover property (S_AXI_RVALID_O && rsel_r[0] && S_AXI_RDATA_O[ST_DONE]);
endmodule // acc_top_assertions
bind acc_top acc_top_assertions i_acc_top_assertions (.*);
`default_nettype wire

// ===== testbench/acc_front_model.sv
// analog front end stand-in: channel code while sampling
// assumes the block synchronises the code
`default_nettype none
module acc_front_model (
    // clock
    input  wire logic       clk_i,
    // block side
    input  wire logic [2:0] channel_i,
    input  wire logic       sample_i,
    // code back to the block
    output var logic [7:0]  code_o
);
    initial code_o = 8'h5a;
    // hold a channel code while sampling, churn otherwise
    always @(posedge clk_i) begin
        if (sample_i) code_o <= {1'b0, channel_i, 1'b1, channel_i};
        else code_o <= ~code_o;
    end
endmodule // acc_front_model
`default_nettype wire

// ===== testbench/acc_top_test.sv
// bench for acc_top: registers, times, restart, low power
// assumes acc_pkg and the front-end model
`default_nettype none
module acc_top_test import acc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, low_power;
    logic [7:0]  awaddr, araddr, code;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [2:0]  chan;
    logic        chan_ok, ain_dis, sample, ladder, vref;
    int          fail_count = 0, tests_run = 0, cyc = 0, irqs = 0, t0 = 0;
    acc_top i_acc_top (.CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .LOW_POWER_I(low_power),
        .ADC_CODE_I(code), .ADC_CHANNEL_O(chan), .ADC_CHANNEL_VALID_O(chan_ok), .ADC_AIN_DISABLE_O(ain_dis),
        .ADC_SAMPLE_O(sample), .LADDER_CONNECT_O(ladder), .VREF_CONNECT_O(vref), .CONV_DONE_IRQ_O(irq));
    acc_front_model i_acc_front_model (.clk_i(clk), .channel_i(chan), .sample_i(sample), .code_o(code));
    ////////////////////////////////////////////////////////////////
    // clock, cycle and event counters
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
    end
    ////////////////////////////////////////////////////////////////
    // compare, verdict, hang exit
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic hang(input string what);
        check(what, 32'h0, 32'h1);
        results();
    endtask
    ////////////////////////////////////////////////////////////////
    // bus write, each channel dropped once taken
    task automatic wr(input logic [7:0] a, d, input logic [1:0] exp = RESP_OKAY);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (bvalid === 1'b1) break;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        if (n == 100) hang("write answer");
        check("bresp", bresp, exp);
        bready <= 1'b0;
    endtask
    // bus read, data taken with rvalid and compared
    task automatic rc(input logic [7:0] a, e, input string what, input logic [1:0] exp = RESP_OKAY);
        int n;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (rvalid === 1'b1) break;
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        if (n == 100) hang("read answer");
        check("rresp", rresp, exp);
        check(what, rdata[7:0], e);
        rready <= 1'b0;
    endtask
    // configure, then start
    task automatic start(input logic [2:0] tc, input logic [2:0] ch, input logic lad = 1'b0);
        wr(ADDR_CTRL_SECOND, {2'b00, lad, 1'b1, tc, 1'b0});
        wr(ADDR_CTRL_FIRST, {4'h2, 1'b0, ch});
        wr(ADDR_CTRL_FIRST, {4'ha, 1'b0, ch});
        t0 = cyc;
    endtask
    // wait for done event, judge elapsed cycles
    task automatic wait_done(input int t);
        int n;
        for (n = 0; n < 1400 && irq !== 1'b1; n++) @(posedge clk);
        if (n == 1400) hang("done event");
        check("conv time", (cyc - t0 >= t - 1) && (cyc - t0 <= t + 2), 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs();
        rc(ADDR_CTRL_FIRST, 8'h30, "first reset");
        rc(ADDR_CTRL_SECOND, 8'h10, "second reset");
        rc(ADDR_STATUS, 8'h00, "status reset");
        check("ain disable", ain_dis, 1'b1);
        wr(8'h00, 8'h55, RESP_SLVERR);
        rc(8'hfc, 8'h00, "unmapped", RESP_SLVERR);
        wr(ADDR_STATUS, 8'hff);
        rc(ADDR_STATUS, 8'h00, "status ro");
        wr(ADDR_CTRL_FIRST, 8'h29);
        @(negedge clk);
        check("chan reserved", chan_ok, 1'b0);
    endtask
    task automatic t_times();
        int ns [8] = '{39, 39, 78, 156, 312, 624, 1248, 39};
        for (int i = 0; i < 8; i++) begin
            start(i[2:0], i[2:0]);
            rc(ADDR_STATUS, 8'h10, "busy");
            wait_done(ns[i]);
            rc(ADDR_STATUS, 8'h20, "done");
            rc(ADDR_RESULT, {1'b0, i[2:0], 1'b1, i[2:0]}, "result");
            rc(ADDR_STATUS, 8'h00, "done cleared");
            check("chan valid", chan_ok, 1'b1);
        end
        check("ladder idle", ladder, 1'b0);
    endtask
    task automatic t_restart();
        start(3'b110, 3'd5);
        wr(ADDR_CTRL_FIRST, 8'ha5);
        rc(ADDR_CTRL_FIRST, 8'h25, "start clear");
        wait_done(1248);
        start(3'b000, 3'd2);
        rc(ADDR_STATUS, 8'h10, "restart done");
        rc(ADDR_RESULT, 8'h5d, "old result");
        wait_done(39);
        rc(ADDR_RESULT, 8'h2a, "new result");
    endtask
    task automatic t_low_power();
        int k;
        wr(ADDR_CTRL_SECOND, 8'h30);
        @(negedge clk);
        check("ladder on", ladder, 1'b1);
        start(3'b110, 3'd3, 1'b1);
        k = irqs;
        @(posedge clk);
        low_power <= 1'b1;
        repeat (6) @(posedge clk);
        check("vref off", vref, 1'b0);
        rc(ADDR_STATUS, 8'h00, "abort");
        wr(ADDR_CTRL_SECOND, 8'h3e);
        rc(ADDR_CTRL_SECOND, 8'h10, "held second");
        rc(ADDR_CTRL_FIRST, 8'h30, "held first");
        rc(ADDR_RESULT, 8'h00, "result dropped");
        @(posedge clk);
        low_power <= 1'b0;
        repeat (60) @(posedge clk);
        rc(ADDR_STATUS, 8'h00, "stays idle");
        check("no event", irqs, k);
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, low_power} = 7'h0;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_times();
        t_restart();
        t_low_power();
        results();
    end
endmodule // acc_top_test
`default_nettype wire
